//--- logic/single_wire_eeprom_command_engine.sv
`timescale 1ns/1ps
module single_wire_eeprom_command_engine #(
	parameter int          STBY_TIME_NS = 600000,
	parameter logic [7:0]  DEVICE_ADDR  = 8'h5C  // arbitrary value
) (
	input  wire logic                      clk_sys,
	input  wire logic                      arst_n,
	input  wire logic                      serial_line,
	output logic                           serial_line_drive,
	output logic                           serial_line_oe_n,
	input  wire logic [7:0]                array_rdata,
	input  wire logic                      write_busy,
	input  wire logic [1:0]                protect_bits,
	input  wire logic [3:0]                page_index,
	output logic [7:0]                     page_byte,
	output logic [swe_pkg::ADDR_W-1:0]     addr_ff,
	output logic                           write_enable_latch,
	output swe_pkg::wr_req_type            wr_req_ff,
	output logic                           sync_lost_ff
);
	import swe_pkg::*;

	localparam int STBY_CYC = (STBY_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE, ST_STANDBY, ST_HDR_LOW, ST_MEASURE, ST_ACTIVE
	} link_state_type;
	typedef enum logic [3:0] {
		PH_HEADER, PH_DEVADDR, PH_CMD, PH_ADDR_HI, PH_ADDR_LO,
		PH_WDATA, PH_RDATA, PH_STAT_W, PH_STAT_R
	} phase_type;
	typedef enum logic [1:0] {END_CONT, END_STBY, END_IDLE} end_type;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	// ****************************************************
	// line sampling and standby pulse
	// ****************************************************
	logic s1_ff, s2_ff, s3_ff;
	logic [15:0] hi_cnt_ff;
	logic        line_edge, standby_hit;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
		end else begin
			s1_ff <= serial_line;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	assign line_edge = s2_ff ^ s3_ff;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			hi_cnt_ff <= 16'h0000;
		else if (!s2_ff)
			hi_cnt_ff <= 16'h0000;
		else if (hi_cnt_ff != 16'(STBY_CYC))
			hi_cnt_ff <= hi_cnt_ff + 16'h0001;
	end
	assign standby_hit = s2_ff && (hi_cnt_ff == 16'(STBY_CYC - 1));

	// ****************************************************
	// bit timing
	// ****************************************************
	link_state_type state_ff;
	phase_type      phase_ff, nphase_ff;
	end_type        end_ff;
	logic [PH_W-1:0] ph_ff, te_ff, meas_ff;
	logic [2:0]      edge_cnt_ff;
	logic [3:0]      idx_ff;
	logic [7:0]      rx_sh_ff, tx_sh_ff, cmd_ff;
	logic            sak_ff;
	logic [PH_W-1:0] win_lo, win_hi, half_te;
	logic            tx_slot, rx_take, rx_lost, tx_done, dec_ev, ack;

	assign half_te = te_ff >> 1;
	assign win_lo  = te_ff - (te_ff >> 2);
	assign win_hi  = te_ff + (te_ff >> 2);
	assign tx_slot = (idx_ff == SACK_IDX) || (idx_ff < MACK_IDX &&
		(phase_ff == PH_RDATA || phase_ff == PH_STAT_R));
	// boundary edges fall before the window and are ignored
	assign rx_take = state_ff == ST_ACTIVE && !tx_slot && line_edge &&
		ph_ff >= win_lo && !standby_hit;
	assign rx_lost = state_ff == ST_ACTIVE && !tx_slot && !line_edge &&
		ph_ff > win_hi && !standby_hit;
	assign tx_done = state_ff == ST_ACTIVE && tx_slot && ph_ff == te_ff &&
		!standby_hit;
	assign dec_ev  = rx_take && idx_ff == MACK_IDX;
	assign ack     = s2_ff; // rising mid edge means continue

	// ****************************************************
	// per-byte decision at the master acknowledge
	// ****************************************************
	logic      d_sak, d_busy_rej;
	end_type   d_end;
	phase_type d_phase;

	always_comb begin
		d_sak      = 1'b0;
		d_end      = END_IDLE;
		d_phase    = phase_ff;
		d_busy_rej = write_busy && (rx_sh_ff == CMD_READ ||
			rx_sh_ff == CMD_CUR_READ || rx_sh_ff == CMD_WRITE ||
			rx_sh_ff == CMD_STAT_WRITE || rx_sh_ff == CMD_ZERO_FILL ||
			rx_sh_ff == CMD_ONES_FILL);
		unique case (phase_ff)
			PH_HEADER: begin
				d_end   = ack ? END_CONT : END_IDLE;
				d_phase = PH_DEVADDR;
			end
			PH_DEVADDR: begin
				if (rx_sh_ff == DEVICE_ADDR) begin
					d_sak   = 1'b1;
					d_end   = ack ? END_CONT : END_STBY;
					d_phase = PH_CMD;
				end
			end
			PH_CMD: begin
				if (!d_busy_rej) begin
					unique case (rx_sh_ff)
						CMD_LATCH_SET, CMD_LATCH_CLR,
						CMD_ZERO_FILL, CMD_ONES_FILL: begin
							d_sak = !ack;
							d_end = ack ? END_IDLE : END_STBY;
						end
						CMD_READ, CMD_WRITE: begin
							d_sak   = ack;
							d_end   = ack ? END_CONT : END_IDLE;
							d_phase = PH_ADDR_HI;
						end
						CMD_CUR_READ: begin
							d_sak   = ack;
							d_end   = ack ? END_CONT : END_IDLE;
							d_phase = PH_RDATA;
						end
						CMD_STAT_READ: begin
							d_sak   = ack;
							d_end   = ack ? END_CONT : END_IDLE;
							d_phase = PH_STAT_R;
						end
						CMD_STAT_WRITE: begin
							d_sak   = ack;
							d_end   = ack ? END_CONT : END_IDLE;
							d_phase = PH_STAT_W;
						end
						default: d_sak = 1'b0;
					endcase
				end
			end
			PH_ADDR_HI: begin
				d_sak   = ack;
				d_end   = ack ? END_CONT : END_IDLE;
				d_phase = PH_ADDR_LO;
			end
			PH_ADDR_LO: begin
				// early nack on a write: no cycle, no slave ack
				d_sak   = ack;
				d_end   = ack ? END_CONT : END_IDLE;
				d_phase = (cmd_ff == CMD_WRITE) ? PH_WDATA : PH_RDATA;
			end
			PH_WDATA, PH_RDATA, PH_STAT_R: begin
				d_sak = 1'b1;
				d_end = ack ? END_CONT : END_STBY;
			end
			PH_STAT_W: begin
				d_sak = !ack;
				d_end = ack ? END_IDLE : END_STBY;
			end
		endcase
	end

	// ****************************************************
	// link state, phase and bit counters
	// ****************************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_ff    <= ST_IDLE;
			phase_ff    <= PH_HEADER;
			nphase_ff   <= PH_HEADER;
			end_ff      <= END_IDLE;
			sak_ff      <= 1'b0;
			ph_ff       <= '0;
			te_ff       <= '0;
			meas_ff     <= '0;
			edge_cnt_ff <= 3'h0;
			idx_ff      <= 4'h0;
			rx_sh_ff    <= 8'h00;
			cmd_ff      <= 8'h00;
		end else if (standby_hit) begin
			state_ff <= ST_STANDBY; // standby pulse aborts any command
		end else begin
			unique case (state_ff)
				ST_IDLE: state_ff <= ST_IDLE;
				ST_STANDBY:
					if (line_edge && !s2_ff)
						state_ff <= ST_HDR_LOW;
				ST_HDR_LOW:
					if (line_edge && s2_ff) begin
						state_ff    <= ST_MEASURE;
						edge_cnt_ff <= 3'h0;
						meas_ff     <= '0;
						ph_ff       <= '0;
					end
				ST_MEASURE: begin
					if (edge_cnt_ff != 3'h0)
						meas_ff <= meas_ff + 1'b1;
					if (&meas_ff)
						state_ff <= ST_IDLE;
					else if (line_edge) begin
						edge_cnt_ff <= edge_cnt_ff + 3'h1;
						if (edge_cnt_ff == 3'(MEAS_EDGES)) begin
							// five mid edges span four periods
							te_ff    <= meas_ff >> 2;
							ph_ff    <= '0;
							state_ff <= ST_ACTIVE;
							phase_ff <= PH_HEADER;
							idx_ff   <= HDR_FIRST_IDX;
						end
					end
				end
				ST_ACTIVE: begin
					ph_ff <= ph_ff + 1'b1;
					if (rx_lost) begin
						state_ff <= ST_IDLE;
					end else if (rx_take) begin
						// realign on master ack only; an early data edge
						// clamps to zero rather than wrapping
						ph_ff  <= (idx_ff == MACK_IDX || ph_ff < te_ff) ?
							'0 : ph_ff - te_ff;
						idx_ff <= idx_ff + 4'h1;
						if (idx_ff < MACK_IDX)
							rx_sh_ff <= {rx_sh_ff[6:0], s2_ff};
						if (dec_ev) begin
							sak_ff    <= d_sak;
							end_ff    <= d_end;
							nphase_ff <= d_phase;
							if (phase_ff == PH_CMD)
								cmd_ff <= rx_sh_ff;
						end
					end else if (tx_done) begin
						ph_ff  <= '0;
						idx_ff <= idx_ff + 4'h1;
						if (idx_ff == SACK_IDX) begin
							idx_ff   <= 4'h0;
							phase_ff <= nphase_ff;
							if (end_ff == END_STBY)
								state_ff <= ST_STANDBY;
							else if (end_ff == END_IDLE)
								state_ff <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ****************************************************
	// line driver
	// ****************************************************
	logic tx_bit;

	assign tx_bit = (idx_ff == SACK_IDX) ? 1'b1 : tx_sh_ff[7];

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			serial_line_drive <= 1'b1;
			serial_line_oe_n  <= 1'b1;
		end else if (state_ff != ST_ACTIVE || standby_hit) begin
			serial_line_oe_n <= 1'b1;
		end else if (ph_ff == half_te) begin
			// a slave nack is simply no drive, so no mid edge
			serial_line_oe_n  <= !(tx_slot &&
				(idx_ff != SACK_IDX || sak_ff));
			serial_line_drive <= !tx_bit;
		end else if (tx_done) begin
			serial_line_drive <= tx_bit;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			tx_sh_ff <= 8'h00;
		else if (tx_done && idx_ff == SACK_IDX) begin
			if (nphase_ff == PH_RDATA)
				tx_sh_ff <= array_rdata;
			else
				tx_sh_ff <= {STAT_PAD, protect_bits,
					write_enable_latch, write_busy};
		end else if (tx_done)
			tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
	end

	// ****************************************************
	// address counter and page buffer
	// ****************************************************
	logic [7:0] page_buf_ff [PAGE_BYTES];
	logic [4:0] wcount_ff;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			addr_ff   <= '0;
			wcount_ff <= 5'h00;
		end else if (dec_ev) begin
			unique case (phase_ff)
				PH_ADDR_HI: if (ack)
					addr_ff[ADDR_W-1:8] <= rx_sh_ff[ADDR_W-9:0];
				PH_ADDR_LO: if (ack) begin
					addr_ff[7:0] <= rx_sh_ff;
					wcount_ff    <= 5'h00;
				end
				PH_RDATA:
					addr_ff <= addr_ff + 1'b1;
				PH_WDATA: begin
					addr_ff[3:0] <= addr_ff[3:0] + 4'h1;
					if (wcount_ff != 5'(PAGE_BYTES))
						wcount_ff <= wcount_ff + 5'h01;
				end
				default: addr_ff <= addr_ff;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dec_ev && phase_ff == PH_WDATA)
			page_buf_ff[addr_ff[3:0]] <= rx_sh_ff;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			page_byte <= 8'h00;
		else
			page_byte <= page_buf_ff[page_index];
	end

	// ****************************************************
	// write enable latch and write requests
	// ****************************************************
	logic cmd_nack_ok;

	assign cmd_nack_ok = dec_ev && !ack && phase_ff == PH_CMD &&
		!d_busy_rej;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			write_enable_latch <= 1'b0;
			wr_req_ff          <= '0;
		end else begin
			wr_req_ff.start <= 1'b0;
			if (cmd_nack_ok && rx_sh_ff == CMD_LATCH_SET)
				write_enable_latch <= 1'b1;
			else if (cmd_nack_ok && rx_sh_ff == CMD_LATCH_CLR)
				write_enable_latch <= 1'b0;
			else if (cmd_nack_ok && write_enable_latch &&
				(rx_sh_ff == CMD_ZERO_FILL ||
				rx_sh_ff == CMD_ONES_FILL)) begin
				write_enable_latch <= 1'b0;
				wr_req_ff.start    <= 1'b1;
				wr_req_ff.kind     <= (rx_sh_ff == CMD_ZERO_FILL) ?
					WK_ZERO : WK_ONES;
				wr_req_ff.data     <= (rx_sh_ff == CMD_ZERO_FILL) ?
					8'h00 : 8'hFF;
			end else if (dec_ev && !ack && write_enable_latch &&
				(phase_ff == PH_WDATA || phase_ff == PH_STAT_W)) begin
				// only reached after a data byte
				write_enable_latch <= 1'b0;
				wr_req_ff.start    <= 1'b1;
				wr_req_ff.kind     <= (phase_ff == PH_WDATA) ?
					WK_PAGE : WK_STATUS;
				wr_req_ff.addr     <= {addr_ff[ADDR_W-1:4], 4'h0};
				wr_req_ff.count    <= (wcount_ff == 5'(PAGE_BYTES)) ?
					wcount_ff : wcount_ff + 5'h01;
				wr_req_ff.data     <= rx_sh_ff;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			sync_lost_ff <= 1'b0;
		else
			sync_lost_ff <= rx_lost;
	end

	// ****************************************************
	// checks
	// ****************************************************
	hdr_period_a: assert property (state_ff == ST_MEASURE && line_edge &&
		edge_cnt_ff == 3'(MEAS_EDGES) && !(&meas_ff) && !standby_hit
		|=> te_ff == $past(meas_ff) >> 2 && ph_ff == '0)
		else $error("bit period not taken from header");
	mak_realign_a: assert property (dec_ev && !standby_hit
		|=> ph_ff == '0)
		else $error("no realign on master ack");
	hdr_clear_a: assert property (state_ff == ST_HDR_LOW && line_edge &&
		s2_ff && !standby_hit |=> ph_ff == '0 && meas_ff == '0)
		else $error("header did not clear timing state");
	latch_set_a: assert property (cmd_nack_ok && rx_sh_ff == CMD_LATCH_SET
		&& !standby_hit |=> write_enable_latch)
		else $error("latch not set");
	write_gate_a: assert property ($rose(wr_req_ff.start)
		|-> $past(write_enable_latch) && !write_enable_latch)
		else $error("write without latch or latch kept");
	read_step_a: assert property (dec_ev && phase_ff == PH_RDATA
		&& !standby_hit |=> addr_ff == $past(addr_ff) + 1'b1)
		else $error("read pointer did not advance");
	page_hold_a: assert property (dec_ev && phase_ff == PH_WDATA
		&& !standby_hit |=> addr_ff[ADDR_W-1:4] ==
		$past(addr_ff[ADDR_W-1:4]))
		else $error("page upper bits moved");
	busy_reject_a: assert property (dec_ev && phase_ff == PH_CMD
		&& d_busy_rej && !standby_hit |=> !sak_ff && end_ff == END_IDLE
		##0 !wr_req_ff.start)
		else $error("busy command not rejected");
	lost_idle_a: assert property (rx_lost |=> state_ff == ST_IDLE
		&& sync_lost_ff ##1 serial_line_oe_n)
		else $error("missed edge not handled");
endmodule : single_wire_eeprom_command_engine

//--- logic/swe_pkg.sv
// Operation
// - measure bit period from each start header
// - realign timing on every master acknowledge edge
// - new header clears all resync state
// - decode 03 read, 06 current, 05 status
// - decode 6C array write, 6E status write
// - 96 sets latch, 91 clears latch
// - 6D fills zeros, 67 fills ones
// - read takes two address bytes, streams data
// - read pointer increments, wraps to zero
// - current read skips address, else identical
// - address byte loads at following ack
// - data byte increments counter at ack/nack
// - writes complete only with latch set
// - sixteen byte buffer, nack starts write
// - early nack or standby aborts write
// - page load increments low nibble only
// - latch commands need nack, else idle
// - latch clears at reset and writes
// - master ack is one, nack zero
// - slave ack one, nack no edge
// - busy rejects array reads, writes and fills
package swe_pkg;
	localparam int          CLK_PERIOD_NS  = 25;
	localparam int          ADDR_W         = 11;
	localparam int          PH_W           = 16;
	localparam int          PAGE_BYTES     = 16;
	localparam int          MEAS_EDGES     = 4;
	localparam logic [3:0]  HDR_FIRST_IDX  = 4'h5;
	localparam logic [3:0]  MACK_IDX       = 4'h8;
	localparam logic [3:0]  SACK_IDX       = 4'h9;
	localparam logic [7:0]  CMD_READ       = 8'h03;
	localparam logic [7:0]  CMD_CUR_READ   = 8'h06;
	localparam logic [7:0]  CMD_STAT_READ  = 8'h05;
	localparam logic [7:0]  CMD_WRITE      = 8'h6C;
	localparam logic [7:0]  CMD_STAT_WRITE = 8'h6E;
	localparam logic [7:0]  CMD_LATCH_SET  = 8'h96;
	localparam logic [7:0]  CMD_LATCH_CLR  = 8'h91;
	localparam logic [7:0]  CMD_ZERO_FILL  = 8'h6D;
	localparam logic [7:0]  CMD_ONES_FILL  = 8'h67;
	localparam logic [3:0]  STAT_PAD       = 4'h0;

	typedef enum logic [1:0] {
		WK_PAGE, WK_STATUS, WK_ZERO, WK_ONES
	} wr_kind_type;

	typedef struct packed {
		logic              start;
		wr_kind_type       kind;
		logic [ADDR_W-1:0] addr;
		logic [4:0]        count;
		logic [7:0]        data;
	} wr_req_type;
endpackage : swe_pkg

//--- verification/swe_master_model.sv
`timescale 1ns/1ps
// ****************************************************************
// bus master driving the single shared line
// ****************************************************************
module swe_master_model (
	output logic       m_en,
	output logic       m_val,
	input  wire logic  line,
	output logic [7:0] rx_byte,
	output logic       rx_valid
);
	time half = 100;
	time skew = 0;
	time lag  = 0;

	initial begin
		m_en     = 1'b1;
		m_val    = 1'b1;
		rx_byte  = 8'h00;
		rx_valid = 1'b0;
	end

	// inverse level first, value after the mid edge
	task automatic tx_bit(input logic v, input time ex);
		m_en  = 1'b1;
		m_val = ~v;
		#(half - skew + ex);
		skew  = 0;
		m_val = v;
		#(half);
	endtask : tx_bit

	// slave edges trail ours, so both halves are sampled late
	task automatic rx_slot(output logic [1:0] s);
		m_en = 1'b0;
		#(half + 25 - skew);
		s[1] = line;
		#(half);
		s[0] = line;
		skew = 25;
	endtask : rx_slot

	task automatic stby();
		m_en  = 1'b1;
		m_val = 1'b1;
		skew  = 0;
		#3000;
	endtask : stby

	task automatic hdr();
		logic [1:0] s;
		m_en  = 1'b1;
		m_val = 1'b0;
		skew  = 0;
		#(10 * half);
		for (int i = 0; i < 8; i++)
			tx_bit(i[0], 0);
		tx_bit(1'b1, 0);
		rx_slot(s);
	endtask : hdr

	task automatic byte_tx(input logic [7:0] b, input logic master_ack,
			output logic [1:0] s);
		for (int i = 7; i >= 0; i--)
			tx_bit(b[i], 0);
		tx_bit(master_ack, lag);
		rx_slot(s);
	endtask : byte_tx

	task automatic byte_rx(input logic master_ack, output logic [1:0] s);
		logic [1:0] t;
		for (int i = 7; i >= 0; i--) begin
			rx_slot(t);
			rx_byte[i] = t[0];
		end
		rx_valid = 1'b1;
		#1;
		rx_valid = 1'b0;
		tx_bit(master_ack, lag);
		rx_slot(s);
	endtask : byte_rx
endmodule : swe_master_model

//--- verification/tb.sv
`timescale 1ns/1ps
// ****************************************************************
// command engine bench
// ****************************************************************
module tb;
	import swe_pkg::*;
	localparam logic [7:0] DEV = 8'h5C; // arbitrary device code
	logic              clk_sys;
	logic              arst_n;
	logic              write_busy;
	logic [1:0]        protect_bits;
	logic [3:0]        page_index;
	logic [7:0]        page_byte;
	logic [ADDR_W-1:0] addr_ff;
	logic              write_enable_latch;
	wr_req_type        wr_req_ff;
	logic              sync_lost_ff;
	logic              drv;
	logic              oe_n;
	logic              m_en;
	logic              m_val;
	logic [7:0]        rx_byte;
	logic              rx_valid;
	wire logic         line;
	wire logic [7:0]   array_rdata;
	int                num_errors = 0;
	int                comparisons = 0;
	int                n_sync = 0;
	wr_req_type        q_wr[$];
	logic [7:0]        q_rd[$];
	logic [7:0]        busy_cmd [6] = '{CMD_READ, CMD_CUR_READ, CMD_WRITE,
		CMD_STAT_WRITE, CMD_ZERO_FILL, CMD_ONES_FILL};
	logic [7:0]        fill_cmd [3] = '{CMD_ZERO_FILL, CMD_ONES_FILL,
		CMD_STAT_WRITE};
	wr_kind_type       fill_kind [3] = '{WK_ZERO, WK_ONES, WK_STATUS};
	logic [7:0]        fill_data [3] = '{8'h00, 8'hFF, 8'h00};

	function automatic logic [7:0] mem_of(input logic [10:0] a);
		return a[7:0] ^ {5'h00, a[10:8]} ^ 8'h3C;
	endfunction : mem_of

	// slave driver is current limited, so the master wins an overlap;
	// a line that nobody drives is pulled high
	assign line = m_en ? m_val : (!oe_n ? drv : 1'b1);
	assign array_rdata = mem_of(addr_ff);

	single_wire_eeprom_command_engine #(
		.STBY_TIME_NS(2000),
		.DEVICE_ADDR (DEV)
	) i_single_wire_eeprom_command_engine (
		.clk_sys(clk_sys), .arst_n(arst_n), .serial_line(line),
		.serial_line_drive(drv), .serial_line_oe_n(oe_n),
		.array_rdata(array_rdata), .write_busy(write_busy),
		.protect_bits(protect_bits), .page_index(page_index),
		.page_byte(page_byte), .addr_ff(addr_ff),
		.write_enable_latch(write_enable_latch),
		.wr_req_ff(wr_req_ff), .sync_lost_ff(sync_lost_ff)
	);
	swe_master_model i_swe_master_model (
		.m_en(m_en), .m_val(m_val), .line(line),
		.rx_byte(rx_byte), .rx_valid(rx_valid)
	);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic op(input logic [7:0] c, input logic master_ack,
			input logic [1:0] exp);
		logic [1:0] s;
		i_swe_master_model.stby();
		i_swe_master_model.hdr();
		i_swe_master_model.byte_tx(DEV, 1'b1, s);
		chk(s, 2'b01);
		i_swe_master_model.byte_tx(c, master_ack, s);
		chk(s, exp);
	endtask : op

	task automatic tx(input logic [7:0] b, input logic master_ack,
			input logic [1:0] exp);
		logic [1:0] s;
		i_swe_master_model.byte_tx(b, master_ack, s);
		chk(s, exp);
	endtask : tx

	task automatic rx(input logic [7:0] e, input logic master_ack);
		logic [1:0] s;
		q_rd.push_back(e);
		i_swe_master_model.byte_rx(master_ack, s);
		chk(s, 2'b01);
	endtask : rx

	task automatic latch(input logic v);
		op(v ? CMD_LATCH_SET : CMD_LATCH_CLR, 1'b0, 2'b01);
		chk(write_enable_latch, v);
	endtask : latch

	task automatic waddr(input logic [10:0] a);
		tx({5'h00, a[10:8]}, 1'b1, 2'b01);
		tx(a[7:0], 1'b1, 2'b01);
		chk(addr_ff, a);
	endtask : waddr

	always @(posedge clk_sys) begin
		wr_req_type e;
		if (sync_lost_ff === 1'b1)
			n_sync++;
		if (wr_req_ff.start === 1'b1) begin
			if (q_wr.size() == 0) begin
				chk(16'h0001, 16'h0000);
			end else begin
				e = q_wr.pop_front();
				chk(wr_req_ff.kind, e.kind);
				if (e.kind == WK_PAGE) begin
					chk(wr_req_ff.addr, e.addr);
					chk(wr_req_ff.count, e.count);
				end else begin
					chk(wr_req_ff.data, e.data);
				end
			end
		end
	end

	always @(posedge rx_valid) begin
		if (q_rd.size() == 0)
			chk(16'h0001, 16'h0000);
		else
			chk(rx_byte, q_rd.pop_front());
	end

	initial begin
		#2000000;
		num_errors++;
		complete_run();
	end

	initial begin
		logic [10:0] pa;
		logic [7:0]  d [3];
		wr_req_type  e;
		arst_n       = 1'b0;
		write_busy   = 1'b0;
		protect_bits = 2'b00;
		page_index   = 4'h0;
		void'($urandom(45569));
		repeat (5) @(negedge clk_sys);
		arst_n = 1'b1;
		chk({oe_n, drv, write_enable_latch, sync_lost_ff, wr_req_ff.start},
			5'b11000);
		chk(addr_ff, 11'h000);
		latch(1'b1);
		latch(1'b0);
		op(CMD_LATCH_SET, 1'b1, 2'b11);
		chk(write_enable_latch, 1'b0);
		// read runs over the top address
		op(CMD_READ, 1'b1, 2'b01);
		waddr(11'h7FE);
		for (int k = 0; k < 3; k++)
			rx(mem_of(11'(11'h7FE + k)), k < 2);
		chk(addr_ff, 11'h001);
		op(CMD_CUR_READ, 1'b1, 2'b01);
		rx(mem_of(11'h001), 1'b0);
		chk(addr_ff, 11'h002);
		@(negedge clk_sys);
		protect_bits = 2'($urandom);
		op(CMD_STAT_READ, 1'b1, 2'b01);
		rx({4'h0, protect_bits, 2'b00}, 1'b0);
		@(negedge clk_sys);
		write_busy = 1'b1;
		foreach (busy_cmd[i])
			op(busy_cmd[i], 1'b1, 2'b11);
		@(negedge clk_sys);
		write_busy = 1'b0;
		op(CMD_WRITE, 1'b1, 2'b01);
		waddr(11'h055);
		tx(8'hA7, 1'b0, 2'b01);
		// page write crossing the page end, acks sent 20 ns late
		latch(1'b1);
		pa = {7'($urandom), 4'hE};
		for (int k = 0; k < 3; k++)
			d[k] = 8'($urandom);
		e = '{1'b1, WK_PAGE, {pa[10:4], 4'h0}, 5'd3, 8'h00};
		q_wr.push_back(e);
		i_swe_master_model.lag = 20;
		op(CMD_WRITE, 1'b1, 2'b01);
		waddr(pa);
		for (int k = 0; k < 3; k++)
			tx(d[k], k < 2, 2'b01);
		i_swe_master_model.lag = 0;
		chk(addr_ff, {pa[10:4], 4'h1});
		chk(write_enable_latch, 1'b0);
		for (int k = 0; k < 3; k++) begin
			@(negedge clk_sys);
			page_index = 4'(4'hE + k);
			repeat (2) @(negedge clk_sys);
			chk(page_byte, d[k]);
		end
		latch(1'b1);
		op(CMD_WRITE, 1'b1, 2'b01);
		tx(8'h00, 1'b1, 2'b01);
		tx(8'h10, 1'b0, 2'b11);
		op(CMD_WRITE, 1'b1, 2'b01);
		waddr(11'h020);
		tx(8'h5A, 1'b1, 2'b01);
		i_swe_master_model.stby();
		chk(write_enable_latch, 1'b1);
		for (int k = 0; k < 3; k++) begin
			e = '{1'b1, fill_kind[k], 11'h000, 5'd0, fill_data[k]};
			if (k == 2)
				e.data = 8'($urandom);
			latch(1'b1);
			q_wr.push_back(e);
			op(fill_cmd[k], k == 2, 2'b01);
			if (k == 2)
				tx(e.data, 1'b0, 2'b01);
			chk(write_enable_latch, 1'b0);
		end
		// line goes quiet in mid byte
		n_sync = 0;
		i_swe_master_model.stby();
		i_swe_master_model.hdr();
		repeat (3) i_swe_master_model.tx_bit(1'b1, 0);
		i_swe_master_model.stby();
		chk(n_sync, 1);
		i_swe_master_model.half = 120;
		latch(1'b1);
		i_swe_master_model.half = 100;
		chk(q_wr.size(), 0);
		complete_run();
	end
endmodule : tb
